//--- logic/sca_regs.svh
// depth and width constants for the stream channel/format adapter
// assumes inclusion by bare name from the adapter sources
`ifndef SCA_REGS_SVH
`define SCA_REGS_SVH
`define SCA_FIFO_DEPTH 32
`define SCA_CH_MAXW    8
`define SCA_EMP_MAXW   8
`define SCA_CNT_W      8
`endif

//--- logic/sca_pkg.sv
// types shared by the stream adapter
// assumes sca_regs.svh is on the include path
`include "sca_regs.svh"
package sca_pkg;
   // side-band fields carried with every beat
   typedef struct packed {
      logic                     sop;
      logic                     eop;
      logic [`SCA_EMP_MAXW-1:0] empty;
      logic [`SCA_CH_MAXW-1:0]  ch;
   } sca_side_t;
endpackage : sca_pkg

//--- logic/sca_adapter.sv
// stream adapter: channel check, buffering, symbol repacking
// assumes both stream parties share clk and keep their ready latency
// How it works
// - channel/error/timing logic only where needed; fifo and repacking buffer always act
// - one symbol width serves both sides
// - packet markers and empty only with packets
// - width zero means the port is unused
// - downstream empty exists when upstream has one
// - separate ready latencies for both sides
// - sink without channel flags nonzero channels
// - source without channel drives channel zero
// - narrower channel zero-extends high bits
// - wider channel drops high source bits
// - flag channels above sink maximum
// - out-of-range beats never reach the sink
// - differing symbol widths cannot be configured
// - repack beats between symbol counts
// - empty generated when source lacks one
// - valid optional upstream, always driven downstream
// - sink ready back-pressures the source
// - error bits routed by matching position
// - all transfers on rising clk
// - valid only when ready latency allows
`timescale 1ns/1ps
`include "sca_regs.svh"

// ==========================================
// fifo
module sca_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = `SCA_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         reset,
   // fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data,
   // fill level
   output logic [$clog2(DEPTH+1)-1:0] count
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_ff, rd_ff;
   logic [AW:0]   cnt_ff;
   wire push = in_valid && in_ready;
   wire pop  = out_valid && out_ready;
   assign in_ready  = cnt_ff != (AW+1)'(DEPTH);
   assign out_valid = cnt_ff != '0;
   assign out_data  = mem[rd_ff];
   assign count     = cnt_ff;
   // storage has no reset, pointers do
   always_ff @(posedge clk) begin
      if (push) mem[wr_ff] <= in_data;
   end
   // pointers wrap at depth, which need not be a power of two
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
         if (pop)  rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   a_fifo_bound: assert property (@(posedge clk) disable iff (reset)
      cnt_ff <= (AW+1)'(DEPTH)) else $error("fifo count past depth");
endmodule : sca_fifo

// ==========================================
// adapter top
module sca_adapter #(
   parameter int SYM_W      = 8,
   parameter int IN_SYMS    = 4,
   parameter int OUT_SYMS   = 1,
   parameter bit USE_PACKET = 1,
   parameter int IN_CH_W    = 2,
   parameter int IN_MAX_CH  = 3,
   parameter int OUT_CH_W   = 1,
   parameter int OUT_MAX_CH = 1,
   parameter int IN_ERR_W   = 1,
   parameter int OUT_ERR_W  = 1,
   parameter bit IN_USE_EMPTY = 1,
   parameter int EMP_W      = 2,
   parameter bit IN_USE_VALID = 1,
   parameter bit OUT_USE_READY = 1,
   parameter int IN_LAT     = 0,
   parameter int OUT_LAT    = 0,
   parameter int DEPTH      = `SCA_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        reset,
   // upstream source
   input  wire logic                        in_valid,
   output logic                             in_ready,
   input  wire logic [IN_SYMS*SYM_W-1:0]    in_data,
   input  wire logic [(IN_CH_W>0?IN_CH_W:1)-1:0]   in_ch,
   input  wire logic [(IN_ERR_W>0?IN_ERR_W:1)-1:0] in_err,
   input  wire logic                        in_sop,
   input  wire logic                        in_eop,
   input  wire logic [EMP_W-1:0]            in_empty,
   // downstream sink
   output logic                             out_valid,
   input  wire logic                        out_ready,
   output logic [OUT_SYMS*SYM_W-1:0]        out_data,
   output logic [(OUT_CH_W>0?OUT_CH_W:1)-1:0]   out_ch,
   output logic [(OUT_ERR_W>0?OUT_ERR_W:1)-1:0] out_err,
   output logic                             out_sop,
   output logic                             out_eop,
   output logic [EMP_W-1:0]                 out_empty,
   // status
   output logic                             ch_err
);
   localparam int CNW = `SCA_CNT_W;
   localparam int EW  = IN_ERR_W > 0 ? IN_ERR_W : 1;
   localparam int IDW = IN_SYMS*SYM_W;
   localparam int ODW = OUT_SYMS*SYM_W;
   localparam int BS  = IN_SYMS + OUT_SYMS;
   localparam int BW  = BS*SYM_W;
   localparam int FW  = $bits(sca_pkg::sca_side_t) + EW + IDW;
   localparam int SMAX = (OUT_CH_W > 0) ? OUT_MAX_CH : 0;

   // one block, unused paths fold away
   // channel check, error routing, repacking and latency gating all sit here;
   // a parameter set that needs no adaptation still registers every beat in the fifo and the repacking buffer

   // ==========================================
   // intake and channel check
   // single symbol width, so a mismatch is not expressible
   // SYM_W shared by both data ports
   // unused upstream valid is taken as always high
   wire v_in = IN_USE_VALID ? in_valid : 1'b1;
   // with latency the source only drives valid in allowed cycles
   wire take = v_in && (IN_LAT == 0 ? in_ready : 1'b1);
   // zero channel width means channel 0
   wire [`SCA_CH_MAXW-1:0] ch_in = (IN_CH_W > 0) ? `SCA_CH_MAXW'(in_ch) : '0;
   // channel beyond sink maximum; no sink channel gives max 0
   wire ch_bad = ch_in > `SCA_CH_MAXW'(SMAX);
   logic [$clog2(DEPTH+1)-1:0] f_cnt;
   logic f_in_ready, f_valid, f_pop;
   logic [FW-1:0] f_word;
   sca_pkg::sca_side_t s_in, s_out;
   logic [EW-1:0] e_out;
   logic [IDW-1:0] d_out;
   // keep room for beats already promised by the latency
   assign in_ready = (32'(f_cnt) + IN_LAT < DEPTH) && f_in_ready;
   // markers only when packets are in use
   assign s_in.sop   = USE_PACKET && in_sop;
   assign s_in.eop   = USE_PACKET && in_eop;
   assign s_in.empty = (USE_PACKET && IN_USE_EMPTY) ? `SCA_EMP_MAXW'(in_empty) : '0;
   assign s_in.ch    = ch_in;
   assign {s_out, e_out, d_out} = f_word;

   // error pulse one cycle after the offending beat
   // rising edge transfers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) ch_err <= 1'b0;
      else       ch_err <= take && ch_bad;
   end

   sca_fifo #(.W(FW), .DEPTH(DEPTH)) u_fifo (
      .clk       (clk),
      .reset     (reset),
      .in_valid  (take && !ch_bad),
      .in_ready  (f_in_ready),
      .in_data   ({s_in, EW'(in_err), in_data}),
      .out_valid (f_valid),
      .out_ready (f_pop),
      .out_data  (f_word),
      .count     (f_cnt)
   );

   // ==========================================
   // repacking buffer
   logic [BW-1:0]  buf_ff, nxt_buf;
   logic [CNW-1:0] cnt_ff, nxt_cnt;
   logic           eop_pend_ff, sop_pend_ff;
   logic [`SCA_CH_MAXW-1:0] ch_ff;
   logic [EW-1:0]  err_ff;
   logic [OUT_LAT:0] rdy_hist_ff;
   wire [CNW-1:0] osym = CNW'(OUT_SYMS);
   wire [CNW-1:0] nsym = CNW'(IN_SYMS) - (s_out.eop ? CNW'(s_out.empty) : '0);
   wire have  = (cnt_ff >= osym) || (eop_pend_ff && cnt_ff != '0);
   wire last  = eop_pend_ff && cnt_ff <= osym;
   // sink latency, valid only where ready was seen
   // index 0 is ready in this very cycle, index L is ready L cycles back
   wire [OUT_LAT+1:0] rdy_all = {rdy_hist_ff, out_ready};
   wire allow = !OUT_USE_READY || rdy_all[OUT_LAT];
   wire fire  = have && allow;
   wire [CNW-1:0] cnt_a = fire ? (last ? '0 : cnt_ff - osym) : cnt_ff;
   // load while the whole next beat fits
   assign f_pop = f_valid && !eop_pend_ff && (cnt_a + CNW'(IN_SYMS) <= CNW'(BS));
   // earliest symbols live at the top of the buffer
   wire [BW-1:0] shifted = fire ? buf_ff << ODW : buf_ff;
   wire [BW-1:0] keep_m  = ~({BW{1'b1}} >> (32'(cnt_a) * SYM_W));
   wire [BW-1:0] ext     = {d_out, {ODW{1'b0}}};
   assign nxt_buf = f_pop ? ((shifted & keep_m) | (ext >> (32'(cnt_a) * SYM_W))) : shifted;
   assign nxt_cnt = f_pop ? cnt_a + nsym : cnt_a;

   // ready history, bit 0 is the previous cycle
   always_ff @(posedge clk or posedge reset) begin
      if (reset) rdy_hist_ff <= '0;
      else       rdy_hist_ff <= (OUT_LAT+1)'({rdy_hist_ff, out_ready});
   end

   // buffer state; load and flush never collide on the markers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         buf_ff      <= '0;
         cnt_ff      <= '0;
         eop_pend_ff <= 1'b0;
         sop_pend_ff <= 1'b0;
         ch_ff       <= '0;
         err_ff      <= '0;
      end else begin
         buf_ff <= nxt_buf;
         cnt_ff <= nxt_cnt;
         if (f_pop) begin
            eop_pend_ff <= s_out.eop;
            sop_pend_ff <= s_out.sop || (sop_pend_ff && !fire);
            ch_ff       <= s_out.ch;
            err_ff      <= e_out;
         end else if (fire) begin
            if (last) eop_pend_ff <= 1'b0;
            sop_pend_ff <= 1'b0;
         end
      end
   end

   // ==========================================
   // downstream outputs
   // payload is buffer state, frozen until fire
   assign out_valid = fire;
   assign out_data  = buf_ff[BW-1 -: ODW];
   assign out_sop   = sop_pend_ff;
   assign out_eop   = last;
   // empty generated from the symbol count
   assign out_empty = last ? EMP_W'(osym - cnt_ff) : '0;
   assign out_ch    = (IN_CH_W > 0) ? $bits(out_ch)'(ch_ff) : '0;
   // error bits matched by position, missing ones zero
   for (genvar i = 0; i < $bits(out_err); i++) begin : g_err
      assign out_err[i] = (i < IN_ERR_W && OUT_ERR_W > 0) ? err_ff[i % EW] : 1'b0;
   end

   // ==========================================
   // checks
   sequence s_bad_take;
      take && ch_bad;
   endsequence
   // a beat waits in the buffer while the sink holds it off
   sequence s_stall;
      have && !allow;
   endsequence
   sequence s_last_beat;
      out_valid && out_eop;
   endsequence
   a_bad_flag: assert property (@(posedge clk) disable iff (reset)
      s_bad_take |=> ch_err) else $error("out-of-range channel not flagged");
   a_bad_dropped: assert property (@(posedge clk) disable iff (reset)
      s_bad_take |=> $stable(f_cnt) || $past(f_pop)) else $error("bad beat stored");
   a_no_ch_zero: assert property (@(posedge clk) disable iff (reset)
      IN_CH_W == 0 |-> out_ch == '0) else $error("channel not zero");
   a_lat_gate: assert property (@(posedge clk) disable iff (reset)
      out_valid && OUT_USE_READY |-> ((OUT_LAT == 0) ? out_ready : $past(out_ready, (OUT_LAT > 0) ? OUT_LAT : 1)))
      else $error("valid outside latency");
   a_stall_hold: assert property (@(posedge clk) disable iff (reset)
      s_stall |=> $stable(out_data) && $stable(out_eop)) else $error("payload changed in stall");
   a_ch_in_range: assert property (@(posedge clk) disable iff (reset)
      out_valid |-> 32'(ch_ff) <= SMAX) else $error("out-of-range channel delivered");
   // no error pulse without a beat
   a_err_quiet: assert property (@(posedge clk) disable iff (reset)
      !take |=> !ch_err) else $error("error pulse without beat");
   a_last_flush: assert property (@(posedge clk) disable iff (reset)
      s_last_beat |=> cnt_ff == '0 && !eop_pend_ff) else $error("symbols left after packet end");
   a_full_beat: assert property (@(posedge clk) disable iff (reset)
      out_valid && !out_eop |-> cnt_ff >= osym) else $error("partial beat sent");
   a_eop_empty: assert property (@(posedge clk) disable iff (reset)
      out_valid && out_eop |-> 32'(out_empty) + 32'(cnt_ff) == OUT_SYMS) else $error("empty wrong");
   a_room_kept: assert property (@(posedge clk) disable iff (reset)
      in_ready |-> 32'(f_cnt) + IN_LAT < DEPTH) else $error("ready without room");
endmodule : sca_adapter

//--- test/sca_sink_model.sv
// downstream sink model: ready pattern, records taken beats
// assumes zero output ready latency and default widths
`timescale 1ns/1ps
// ==========
// sink model
module sca_sink_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // stream from the adapter
   input  wire logic       out_valid,
   output logic            out_ready,
   input  wire logic [7:0] out_data,
   input  wire logic       out_ch,
   input  wire logic       out_sop,
   input  wire logic       out_eop,
   input  wire logic [1:0] out_empty,
   // 0 always ready, 1 every other cycle, 2 stalled
   input  wire logic [1:0] mode
);
   logic [12:0] got[$];
   logic        tick_ff;
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         out_ready <= 1'h0;
         tick_ff   <= 1'h0;
      end else begin
         tick_ff   <= ~tick_ff;
         out_ready <= (mode == 2'h0) || (mode == 2'h1 && tick_ff);
         // taken only when ready was shown in the same cycle
         if (out_valid && out_ready)
            got.push_back({out_data, out_ch, out_sop, out_eop, out_empty});
      end
   end
endmodule : sca_sink_model

//--- test/sca_adapter_bench.sv
// bench for the stream adapter: 4 to 1 symbol repack, channel check
// assumes default parameters of the adapter
`timescale 1ns/1ps
module sca_adapter_bench;
   typedef struct packed {
      logic [31:0] data;
      logic [1:0]  ch;
      logic        sop;
      logic        eop;
      logic [1:0]  empty;
      logic [2:0]  n_out;
      logic        err;
   } sca_row_t;
   sca_row_t rows[6] = '{'{32'h11223344, 2'h0, 1'h1, 1'h0, 2'h0, 3'h4, 1'h0},
                         '{32'hA1B2C3D4, 2'h0, 1'h0, 1'h1, 2'h1, 3'h3, 1'h0},
                         '{32'h55667788, 2'h2, 1'h1, 1'h1, 2'h0, 3'h0, 1'h1},
                         '{32'h99AABBCC, 2'h3, 1'h1, 1'h1, 2'h0, 3'h0, 1'h1},
                         '{32'hDEADBEEF, 2'h0, 1'h1, 1'h1, 2'h3, 3'h1, 1'h0},
                         '{32'h0F1E2D3C, 2'h1, 1'h1, 1'h1, 2'h0, 3'h4, 1'h0}};
   logic clk, reset, in_valid, in_ready, in_sop, in_eop, out_valid, out_ready;
   logic out_ch, out_err, out_sop, out_eop, ch_err;
   logic [31:0] in_data;
   logic [1:0]  in_ch, in_empty, out_empty, mode;
   logic [0:0]  in_err;
   logic [7:0]  out_data;
   logic [12:0] exp_q[$];
   int n_mismatch, samples_checked, n_err_seen, n_err_exp, n;
   sca_adapter i_dut (.clk(clk), .reset(reset), .in_valid(in_valid), .in_ready(in_ready),
      .in_data(in_data), .in_ch(in_ch), .in_err(in_err), .in_sop(in_sop), .in_eop(in_eop),
      .in_empty(in_empty), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
      .out_ch(out_ch), .out_err(out_err), .out_sop(out_sop), .out_eop(out_eop),
      .out_empty(out_empty), .ch_err(ch_err));
   sca_sink_model i_sink (.clk(clk), .reset(reset), .out_valid(out_valid), .out_ready(out_ready),
      .out_data(out_data), .out_ch(out_ch), .out_sop(out_sop), .out_eop(out_eop),
      .out_empty(out_empty), .mode(mode));
   // ==========
   // clock and error pulse counter
   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   always @(negedge clk) if (ch_err === 1'h1) n_err_seen++;
   // ==========
   // compare and driver tasks
   task chk_bit(input logic got, input logic exp, input string what);
      samples_checked++;
      if (got !== exp) begin n_mismatch++; $display("[FAIL] %0t %s", $time, what); end
   endtask : chk_bit
   task chk_word(input logic [12:0] got, input logic [12:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin n_mismatch++; $display("[FAIL] %0t %s %h %h", $time, what, got, exp); end
   endtask : chk_word
   // holds the beat until an edge with ready high takes it
   task send(input sca_row_t r);
      int k, w;
      in_valid <= 1'h1; in_data <= r.data; in_ch <= r.ch; in_err <= r.data[0:0];
      in_sop <= r.sop; in_eop <= r.eop; in_empty <= r.empty;
      w = 0;
      do begin @(negedge clk); w++; end while (in_ready !== 1'h1 && w < 200);
      @(posedge clk);
      n_err_exp += r.err;
      for (k = 0; k < r.n_out; k++)
         exp_q.push_back({r.data[31-8*k -: 8], r.ch[0], r.sop && k == 0, r.eop && k == int'(r.n_out) - 1, 2'h0});
   endtask : send
   task drain;
      int w;
      in_valid <= 1'h0;
      w = 0;
      while (i_sink.got.size() < exp_q.size() && w < 400) begin @(posedge clk); w++; end
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk_word(13'(i_sink.got.size()), 13'(exp_q.size()), "beat count");
      foreach (exp_q[i]) if (i < i_sink.got.size()) chk_word(i_sink.got[i], exp_q[i], "beat");
      chk_bit(out_valid, 1'h0, "valid after drain");
      exp_q.delete();
      i_sink.got.delete();
   endtask : drain
   task stop_test;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      stop_test;
   end
   // ==========
   // main sequence: rows, then fill, then reset in mid-run
   initial begin
      reset = 1'h1; mode = 2'h0; in_valid = 1'h0; in_data = 32'h0; in_ch = 2'h0;
      in_err = 1'h0; in_sop = 1'h0; in_eop = 1'h0; in_empty = 2'h0;
      repeat (4) @(posedge clk);
      chk_bit(in_ready, 1'h1, "ready in reset");
      chk_bit(out_valid, 1'h0, "valid in reset");
      reset <= 1'h0;
      @(posedge clk);
      mode <= 2'h1;
      foreach (rows[i]) send(rows[i]);
      drain();
      chk_word(13'(n_err_seen), 13'(n_err_exp), "channel errors");
      // sink stalled until the buffer refuses
      mode <= 2'h2;
      for (n = 0; n < 40; n++) begin
         in_valid <= 1'h0;
         @(negedge clk);
         if (in_ready !== 1'h1) break;
         @(posedge clk);
         send(rows[5]);
      end
      chk_bit(n >= 32 && n < 40, 1'h1, "buffer refusal point");
      @(posedge clk);
      mode <= 2'h0;
      drain();
      send(rows[5]);
      reset <= 1'h1;
      in_valid <= 1'h0;
      @(negedge clk);
      chk_bit(out_valid, 1'h0, "valid in second reset");
      chk_bit(in_ready, 1'h1, "ready in second reset");
      @(posedge clk);
      reset <= 1'h0;
      exp_q.delete();
      i_sink.got.delete();
      @(posedge clk);
      send(rows[4]);
      drain();
      stop_test;
   end
endmodule : sca_adapter_bench
